// [shared/tmr_pkg.sv]
// package for the 16-bit timer with capture, compare and pwm channels
// assumes an 8-bit register port with byte-wide registers at fixed offsets
package tmr_pkg;
   localparam int          NUM_CH          = 2;
   // register offsets (byte registers)
   localparam logic [4:0]  ADDR_MAIN_SC    = 5'h00;
   localparam logic [4:0]  ADDR_CNT_HI     = 5'h01;
   localparam logic [4:0]  ADDR_CNT_LO     = 5'h02;
   localparam logic [4:0]  ADDR_MOD_HI     = 5'h03;
   localparam logic [4:0]  ADDR_MOD_LO     = 5'h04;
   localparam logic [4:0]  ADDR_CH_BASE    = 5'h05;
   localparam logic [4:0]  CH_STRIDE       = 5'h03;
   localparam logic [1:0]  CH_OFS_SC       = 2'h0;
   localparam logic [1:0]  CH_OFS_VHI      = 2'h1;
   localparam logic [1:0]  CH_OFS_VLO      = 2'h2;
   // main status/control fields
   localparam int          SC_OVF_BIT      = 7;
   localparam int          SC_OVIE_BIT     = 6;
   localparam int          SC_CENTER_ALIGNED_PWM_BIT     = 5;
   localparam int          SC_CLKHI_BIT    = 4;
   localparam int          SC_CLKLO_BIT    = 3;
   // channel status/control fields
   localparam int          CSC_FLAG_BIT    = 7;
   localparam int          CSC_IE_BIT      = 6;
   localparam int          CSC_MSB_BIT     = 5;
   localparam int          CSC_MSA_BIT     = 4;
   localparam int          CSC_ELSB_BIT    = 3;
   localparam int          CSC_ELSA_BIT    = 2;
   // reset values
   localparam logic [7:0]  SC_RESET        = 8'h00;
   localparam logic [7:0]  CSC_RESET       = 8'h00;
   localparam logic [15:0] CNT_RESET       = 16'h0000;
   localparam logic [15:0] MOD_RESET       = 16'h0000;
   localparam logic [15:0] VAL_RESET       = 16'h0000;
   localparam logic [15:0] CNT_ALL_ONES    = 16'hffff;
   localparam logic [15:0] CNT_ONES_M1     = 16'hfffe;
endpackage : tmr_pkg

// [hdl/tmr_top.sv]
// 16-bit timer counter with per-channel capture, compare, edge and center pwm
// assumes byte register port, inputs synchronous to sys_clk, sync active-high rst
`timescale 1ns/100ps
// =============================================================
module tmr_top (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic [4:0]                  reg_addr,
   input  wire logic [7:0]                  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [7:0]                  reg_rdata,
   input  wire logic                        background_debug_mode,
   input  wire logic [tmr_pkg::NUM_CH-1:0]  timer_channel_pin_in,
   output logic      [tmr_pkg::NUM_CH-1:0]  timer_channel_pin_out,
   output logic      [tmr_pkg::NUM_CH-1:0]  timer_channel_pin_oe,
   output logic                             overflow_irq,
   output logic      [tmr_pkg::NUM_CH-1:0]  channel_irq
);
   localparam int N = tmr_pkg::NUM_CH;

   typedef struct packed {
      logic [7:0]         sc;
      logic [15:0]        cnt;
      logic               down;
      logic [15:0]        modv;
      logic [7:0]         mod_hb;
      logic               mod_hb_ok;
      logic [7:0]         rd_latch;
      logic               rd_latch_ok;
      logic [N-1:0][7:0]  csc;
      logic [N-1:0][15:0] val;
      logic [N-1:0][7:0]  vb_hi;
      logic [N-1:0][7:0]  vb_lo;
      logic [N-1:0]       vhi_ok;
      logic [N-1:0]       vlo_ok;
      logic [N-1:0]       vpend;
      logic [N-1:0]       pout;
      logic [N-1:0]       pin_q;
      logic [7:0]         rdata;
   } tmr_state_t;

   tmr_state_t st;
   tmr_state_t next_st;

   // =============================================================
   // helpers
   function automatic logic tmr_free(input logic [15:0] m);
      tmr_free = (m == 16'h0000) || (m == tmr_pkg::CNT_ALL_ONES);
   endfunction : tmr_free

   function automatic logic tmr_is_ch(input logic [4:0] a, input int c,
                                      input logic [1:0] ofs);
      logic [4:0] base;
      base = tmr_pkg::ADDR_CH_BASE + 5'(c) * tmr_pkg::CH_STRIDE;
      tmr_is_ch = (a == base + 5'(ofs));
   endfunction : tmr_is_ch

   logic        clk_on;
   logic        center_aligned_pwm;
   logic        free_run;
   logic [15:0] top;
   logic        at_top;
   logic        hit_top_step;
   always_comb begin
      clk_on       = st.sc[tmr_pkg::SC_CLKHI_BIT] | st.sc[tmr_pkg::SC_CLKLO_BIT];
      center_aligned_pwm         = st.sc[tmr_pkg::SC_CENTER_ALIGNED_PWM_BIT];
      free_run     = tmr_free(st.modv);
      top          = free_run ? tmr_pkg::CNT_ALL_ONES : st.modv;
      at_top       = (st.cnt == top);
      // step into top value from the one before; used for center-pwm reload
      hit_top_step = clk_on && !st.down && (st.cnt == top - 16'h0001);
   end

   // =============================================================
   // next state
   always_comb begin
      logic [1:0] ms;
      logic [1:0] els;
      logic       match;
      logic       rise;
      logic       fall;
      logic       ovf_set;
      logic [N-1:0] flag_set;
      ms      = 2'b00;
      ovf_set = 1'b0;
      flag_set = '0;
      els     = 2'b00;
      match   = 1'b0;
      rise    = 1'b0;
      fall    = 1'b0;
      next_st = st;
      // counter: modulo up, or up/down when center select set
      if (clk_on) begin
         if (center_aligned_pwm) begin
            if (!st.down) begin
               if (at_top) begin
                  next_st.down = 1'b1;
                  next_st.cnt  = st.cnt - 16'h0001;
               end else begin
                  next_st.cnt  = st.cnt + 16'h0001;
               end
            end else if (st.cnt == 16'h0000) begin
               next_st.down = 1'b0;
               next_st.cnt  = 16'h0001;
            end else begin
               next_st.cnt  = st.cnt - 16'h0001;
            end
         end else begin
            next_st.down = 1'b0;
            next_st.cnt  = at_top ? 16'h0000 : st.cnt + 16'h0001;
         end
         // count at top (modulo, or ffff when free-running) sets overflow, only counting up in center mode
         if (at_top && (!center_aligned_pwm || !st.down)) begin
            ovf_set = 1'b1;
            next_st.sc[tmr_pkg::SC_OVF_BIT] = 1'b1;
         end
      end
      // per-channel behaviour
      for (int c = 0; c < N; c++) begin
         ms    = {st.csc[c][tmr_pkg::CSC_MSB_BIT], st.csc[c][tmr_pkg::CSC_MSA_BIT]};
         els   = {st.csc[c][tmr_pkg::CSC_ELSB_BIT], st.csc[c][tmr_pkg::CSC_ELSA_BIT]};
         match = clk_on && (st.cnt == st.val[c]);
         rise  = timer_channel_pin_in[c] & ~st.pin_q[c];
         fall  = ~timer_channel_pin_in[c] & st.pin_q[c];
         next_st.pin_q[c] = timer_channel_pin_in[c];
         if (center_aligned_pwm) begin
            // center pwm regardless of mode bits when channel active
            if (els != 2'b00 && match) begin
               next_st.pout[c] = st.down ? 1'b1 : 1'b0;
               next_st.csc[c][tmr_pkg::CSC_FLAG_BIT] = 1'b1;
               flag_set[c] = 1'b1;
            end
            if (st.vpend[c] && hit_top_step) begin
               next_st.val[c]   = {st.vb_hi[c], st.vb_lo[c]};
               next_st.vpend[c] = 1'b0;
            end
         end else if (ms == 2'b00) begin
            // capture: latch counter on selected edge
            if ((els[0] && rise) || (els[1] && fall)) begin
               next_st.val[c] = st.cnt;
               next_st.csc[c][tmr_pkg::CSC_FLAG_BIT] = 1'b1;
               flag_set[c] = 1'b1;
            end
         end else if (ms == 2'b01) begin
            // compare: toggle, clear or set on match
            if (match) begin
               next_st.csc[c][tmr_pkg::CSC_FLAG_BIT] = 1'b1;
               flag_set[c] = 1'b1;
               unique case (els)
                  2'b01:   next_st.pout[c] = ~st.pout[c];
                  2'b10:   next_st.pout[c] = 1'b0;
                  2'b11:   next_st.pout[c] = 1'b1;
                  default: next_st.pout[c] = st.pout[c];
               endcase
            end
         end else begin
            // edge pwm: flag at duty match; buffered value loads at period end
            if (match) begin
               next_st.csc[c][tmr_pkg::CSC_FLAG_BIT] = 1'b1;
               flag_set[c] = 1'b1;
            end
            if (st.vpend[c] && clk_on && at_top) begin
               next_st.val[c]   = {st.vb_hi[c], st.vb_lo[c]};
               next_st.vpend[c] = 1'b0;
            end
            // active while the coming count is below the value then standing,
            // so zero stays idle and a value above modulo stays active
            if (clk_on)
               next_st.pout[c] = (next_st.cnt < next_st.val[c]) ? ~els[0] : els[0];
         end
         // output compare loads its value once both bytes are in
         if (!center_aligned_pwm && ms == 2'b01 && st.vpend[c]) begin
            next_st.val[c]   = {st.vb_hi[c], st.vb_lo[c]};
            next_st.vpend[c] = 1'b0;
         end
      end
      // =============================================================
      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            tmr_pkg::ADDR_MAIN_SC: begin
               // overflow clears only by writing zero; a same-cycle set wins
               next_st.sc[6:0] = reg_wdata[6:0];
               if (!reg_wdata[tmr_pkg::SC_OVF_BIT])
                  next_st.sc[tmr_pkg::SC_OVF_BIT] = ovf_set;
               next_st.mod_hb_ok   = 1'b0;
               next_st.rd_latch_ok = 1'b0;
            end
            tmr_pkg::ADDR_CNT_HI, tmr_pkg::ADDR_CNT_LO: begin
               next_st.cnt         = tmr_pkg::CNT_RESET;
               next_st.down        = 1'b0;
               next_st.rd_latch_ok = 1'b0;
            end
            tmr_pkg::ADDR_MOD_HI: begin
               next_st.mod_hb    = reg_wdata;
               next_st.mod_hb_ok = 1'b1;
            end
            tmr_pkg::ADDR_MOD_LO: begin
               if (st.mod_hb_ok) begin
                  next_st.modv      = {st.mod_hb, reg_wdata};
                  next_st.mod_hb_ok = 1'b0;
               end
            end
            default: ;
         endcase
         for (int c = 0; c < N; c++) begin
            if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_SC)) begin
               next_st.csc[c][6:2] = reg_wdata[6:2];
               if (!reg_wdata[tmr_pkg::CSC_FLAG_BIT])
                  next_st.csc[c][tmr_pkg::CSC_FLAG_BIT] = flag_set[c];
               next_st.vhi_ok[c] = 1'b0;
               next_st.vlo_ok[c] = 1'b0;
               next_st.vpend[c]  = 1'b0;
            end
            // capture mode refuses value writes
            if (center_aligned_pwm || st.csc[c][5:4] != 2'b00) begin
               if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_VHI)) begin
                  next_st.vb_hi[c]  = reg_wdata;
                  next_st.vhi_ok[c] = 1'b1;
                  if (st.vlo_ok[c]) begin
                     next_st.vhi_ok[c] = 1'b0;
                     next_st.vlo_ok[c] = 1'b0;
                     if (center_aligned_pwm && !clk_on)
                        next_st.val[c] = {reg_wdata, st.vb_lo[c]};
                     else
                        next_st.vpend[c] = 1'b1;
                  end
               end
               if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_VLO)) begin
                  next_st.vb_lo[c]  = reg_wdata;
                  next_st.vlo_ok[c] = 1'b1;
                  if (st.vhi_ok[c]) begin
                     next_st.vhi_ok[c] = 1'b0;
                     next_st.vlo_ok[c] = 1'b0;
                     if (center_aligned_pwm && !clk_on)
                        next_st.val[c] = {st.vb_hi[c], reg_wdata};
                     else
                        next_st.vpend[c] = 1'b1;
                  end
               end
            end
         end
      end
      // =============================================================
      // register reads: data stands the cycle after the strobe
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            tmr_pkg::ADDR_MAIN_SC: next_st.rdata = st.sc;
            tmr_pkg::ADDR_CNT_HI: begin
               // high byte read latches low byte so a pair reads coherently
               next_st.rdata       = st.cnt[15:8];
               if (!(background_debug_mode && st.rd_latch_ok)) begin
                  next_st.rd_latch    = st.cnt[7:0];
                  next_st.rd_latch_ok = 1'b1;
               end
            end
            tmr_pkg::ADDR_CNT_LO: begin
               next_st.rdata = st.rd_latch_ok ? st.rd_latch : st.cnt[7:0];
               if (!background_debug_mode)
                  next_st.rd_latch_ok = 1'b0;
            end
            tmr_pkg::ADDR_MOD_HI:  next_st.rdata = st.modv[15:8];
            tmr_pkg::ADDR_MOD_LO:  next_st.rdata = st.modv[7:0];
            default: ;
         endcase
         for (int c = 0; c < N; c++) begin
            if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_SC))
               next_st.rdata = st.csc[c];
            if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_VHI))
               next_st.rdata = st.val[c][15:8];
            if (tmr_is_ch(reg_addr, c, tmr_pkg::CH_OFS_VLO))
               next_st.rdata = st.val[c][7:0];
         end
      end
   end

   // =============================================================
   // state register; reset clears control, all channels in capture
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st             <= '0;
         st.sc          <= tmr_pkg::SC_RESET;
         st.cnt         <= tmr_pkg::CNT_RESET;
         st.modv        <= tmr_pkg::MOD_RESET;
         for (int c = 0; c < N; c++) begin
            st.csc[c] <= tmr_pkg::CSC_RESET;
            st.val[c] <= tmr_pkg::VAL_RESET;
         end
      end else begin
         st <= next_st;
      end
   end

   // =============================================================
   // outputs; pin released to gpio unless a mode drives it
   always_comb begin
      reg_rdata    = st.rdata;
      overflow_irq = st.sc[tmr_pkg::SC_OVF_BIT] & st.sc[tmr_pkg::SC_OVIE_BIT];
      for (int c = 0; c < N; c++) begin
         timer_channel_pin_out[c] = st.pout[c];
         timer_channel_pin_oe[c]  = (center_aligned_pwm || st.csc[c][5:4] != 2'b00) &&
                                    (st.csc[c][3:2] != 2'b00);
         channel_irq[c] = st.csc[c][tmr_pkg::CSC_FLAG_BIT] & st.csc[c][tmr_pkg::CSC_IE_BIT];
      end
   end

   // =============================================================
   // checks
   property p_cnt_wr_reset;
      @(posedge sys_clk) disable iff (rst)
      reg_wr && (reg_addr == tmr_pkg::ADDR_CNT_LO) |=> st.cnt == 16'h0000;
   endproperty
   a_cnt_wr_reset: assert property (p_cnt_wr_reset) else $error("counter not reset");

   property p_ovf_set;
      @(posedge sys_clk) disable iff (rst)
      clk_on && at_top && !center_aligned_pwm |=> st.sc[tmr_pkg::SC_OVF_BIT];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missing");

   property p_edge_wrap;
      @(posedge sys_clk) disable iff (rst)
      clk_on && !center_aligned_pwm && at_top && !reg_wr |=> st.cnt == 16'h0000;
   endproperty
   a_edge_wrap: assert property (p_edge_wrap) else $error("edge wrap wrong");

   property p_center_turn;
      @(posedge sys_clk) disable iff (rst)
      clk_on && center_aligned_pwm && !st.down && at_top && !reg_wr && top != 16'h0000 |=> st.down;
   endproperty
   a_center_turn: assert property (p_center_turn) else $error("no turn at top");

   property p_rd_stable;
      @(posedge sys_clk) disable iff (rst)
      clk_on && !center_aligned_pwm && !at_top && !reg_wr && reg_rd |=> st.cnt == $past(st.cnt) + 16'h0001;
   endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read disturbed count");

   property p_mod_flush;
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == tmr_pkg::ADDR_MAIN_SC |=> !st.mod_hb_ok;
   endproperty
   a_mod_flush: assert property (p_mod_flush) else $error("modulo buffer kept");

   property p_ch0_flush;
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == tmr_pkg::ADDR_CH_BASE |=> !st.vhi_ok[0] && !st.vlo_ok[0];
   endproperty
   a_ch0_flush: assert property (p_ch0_flush) else $error("channel buffer kept");

   property p_ch1_match_flag;
      @(posedge sys_clk) disable iff (rst)
      clk_on && st.cnt == st.val[1] && !reg_wr &&
      (center_aligned_pwm ? st.csc[1][3:2] != 2'b00 : st.csc[1][5:4] != 2'b00)
      |=> st.csc[1][tmr_pkg::CSC_FLAG_BIT];
   endproperty
   a_ch1_match_flag: assert property (p_ch1_match_flag) else $error("match flag missing");

   c_ovf:    cover property (@(posedge sys_clk) disable iff (rst) clk_on && at_top);
   c_center: cover property (@(posedge sys_clk) disable iff (rst) center_aligned_pwm && st.down);
   c_cap:    cover property (@(posedge sys_clk) disable iff (rst)
                             st.csc[0][5:4] == 2'b00 && st.csc[0][7]);
endmodule : tmr_top

// [tb/tmr_pin_model.sv]
// far-side model: outside sources wired to the timer channel pins
// assumes toggle requests are driven synchronous to sys_clk
`timescale 1ns/100ps
// =============================================================
// pin model
module tmr_pin_model (
   input  wire logic                       sys_clk,
   input  wire logic [tmr_pkg::NUM_CH-1:0] toggle_req,
   input  wire logic [tmr_pkg::NUM_CH-1:0] pin_out,
   input  wire logic [tmr_pkg::NUM_CH-1:0] pin_oe,
   output logic      [tmr_pkg::NUM_CH-1:0] pin_in
);
   logic [tmr_pkg::NUM_CH-1:0] ext_level = '0;
   // the source flips only on request, so every capture edge is one the bench asked for or comes from releasing a driven pin
   always @(posedge sys_clk) begin
      ext_level <= ext_level ^ toggle_req;
   end
   // a driven pin reads back the timer's level, a released one the outside source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : tmr_pin_model

// [tb/testbench.sv]
// self-checking bench: register sequences, flag timing and pin duty checks
// assumes the timer package and the pin model are compiled first
`timescale 1ns/100ps
// =============================================================
// bench top
module testbench;
   logic                       sys_clk;
   logic                       rst;
   logic [4:0]                 reg_addr;
   logic [7:0]                 reg_wdata;
   logic                       reg_wr;
   logic                       reg_rd;
   logic [7:0]                 reg_rdata;
   logic                       background_debug_mode;
   logic [tmr_pkg::NUM_CH-1:0] pin_in;
   logic [tmr_pkg::NUM_CH-1:0] pin_out;
   logic [tmr_pkg::NUM_CH-1:0] pin_oe;
   logic [tmr_pkg::NUM_CH-1:0] toggle_req;
   logic                       overflow_irq;
   logic [tmr_pkg::NUM_CH-1:0] channel_irq;
   logic [7:0]                 b;
   logic [15:0]                v0;
   logic [15:0]                v1;
   int                         err_total = 0;
   int                         checks = 0;
   int                         cyc = 0;
   int                         t_rd;
   int                         t0;
   int                         k;

   tmr_top u_dut (
      .sys_clk               (sys_clk),
      .rst                   (rst),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .background_debug_mode (background_debug_mode),
      .timer_channel_pin_in  (pin_in),
      .timer_channel_pin_out (pin_out),
      .timer_channel_pin_oe  (pin_oe),
      .overflow_irq          (overflow_irq),
      .channel_irq           (channel_irq)
   );
   tmr_pin_model u_pins (
      .sys_clk    (sys_clk),
      .toggle_req (toggle_req),
      .pin_out    (pin_out),
      .pin_oe     (pin_oe),
      .pin_in     (pin_in)
   );

   // =============================================================
   // clock and cycle count
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
   end

   // =============================================================
   // access tasks
   function automatic logic [4:0] ch_a(input int n, input logic [1:0] ofs);
      return tmr_pkg::ADDR_CH_BASE + 5'(n) * tmr_pkg::CH_STRIDE + {3'h0, ofs};
   endfunction : ch_a
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      t_rd = cyc;
      d = reg_rdata;
   endtask : rd
   // high byte first: for the counter it latches the low byte
   task automatic rd16(input logic [4:0] a, output logic [15:0] v);
      logic [7:0] h;
      int         t;
      rd(a, h);
      t = t_rd;
      rd(a + 5'h01, v[7:0]);
      v[15:8] = h;
      t_rd = t;
   endtask : rd16
   task automatic wr16(input logic [4:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 5'h01, v[7:0]);
   endtask : wr16
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // w = 0 watches the overflow request, w = n + 1 the request of channel n
   task automatic wait_hi(input int w, output int t);
      int n;
      n = 0;
      while (((w == 0) ? overflow_irq : channel_irq[w-1]) !== 1'b1) begin
         if (n == 100) begin
            err_total++;
            finish_test();
         end
         n++;
         @(posedge sys_clk);
         #1;
      end
      t = cyc;
   endtask : wait_hi
   // clear then time three sets; the first may be seen late, so only the last pair counts
   task automatic period(input int w, input logic [4:0] a, input logic [7:0] d, output int p);
      int tt [3];
      for (int i = 0; i < 3; i++) begin
         wr(a, d);
         @(posedge sys_clk);
         #1;
         wait_hi(w, tt[i]);
      end
      p = tt[2] - tt[1];
   endtask : period
   task automatic count_hi(input int ch, input int len, output int n);
      n = 0;
      repeat (len) begin
         @(posedge sys_clk);
         #1;
         if (pin_out[ch] === 1'b1) n++;
      end
   endtask : count_hi
   task automatic finish_test();
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   // =============================================================
   // main sequence
   initial begin
      rst = 1'b1;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      background_debug_mode = 1'b0;
      toggle_req = '0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      // reset state: all control cleared, pins released, counter frozen
      rd(tmr_pkg::ADDR_MAIN_SC, b);
      chk("main_ctl", 16'h0000, {8'h00, b});
      for (int n = 0; n < tmr_pkg::NUM_CH; n++) begin
         rd(ch_a(n, tmr_pkg::CH_OFS_SC), b);
         chk("chan_ctl", 16'h0000, {8'h00, b});
      end
      chk("pin_oe", 16'h0000, 16'(pin_oe));
      rd16(tmr_pkg::ADDR_CNT_HI, v0);
      repeat (8) @(posedge sys_clk);
      rd16(tmr_pkg::ADDR_CNT_HI, v1);
      chk("cnt_frozen", 16'h0000, v0 | v1);
      // free-running: reads spaced by a known gap differ by exactly that gap
      wr(tmr_pkg::ADDR_MAIN_SC, 8'h08);
      rd16(tmr_pkg::ADDR_CNT_HI, v0);
      t0 = t_rd;
      repeat (20) @(posedge sys_clk);
      rd16(tmr_pkg::ADDR_CNT_HI, v1);
      chk("cnt_step", 16'(t_rd - t0), v1 - v0);
      wr(tmr_pkg::ADDR_CNT_LO, 8'h55);
      rd16(tmr_pkg::ADDR_CNT_HI, v0);
      chk("cnt_cleared", 16'h0001, 16'(v0 < 16'h0008));
      // modulo 9 gives an overflow every 10 steps; a lone low byte must not land
      wr16(tmr_pkg::ADDR_MOD_HI, 16'h0009);
      period(0, tmr_pkg::ADDR_MAIN_SC, 8'h48, k);
      chk("ovf_period", 16'h000a, 16'(k));
      wr(tmr_pkg::ADDR_MOD_HI, 8'h00);
      wr(tmr_pkg::ADDR_MAIN_SC, 8'h48);
      wr(tmr_pkg::ADDR_MOD_LO, 8'h03);
      period(0, tmr_pkg::ADDR_MAIN_SC, 8'h48, k);
      chk("mod_discard", 16'h000a, 16'(k));
      // capture channel ignores value writes and flags on each pin edge
      wr16(ch_a(0, tmr_pkg::CH_OFS_VHI), 16'h1234);
      rd16(ch_a(0, tmr_pkg::CH_OFS_VHI), v0);
      chk("cap_value", 16'h0000, v0);
      for (int i = 0; i < 2; i++) begin
         wr(ch_a(0, tmr_pkg::CH_OFS_SC), 8'h4c);
         @(posedge sys_clk);
         #1;
         chk("cap_idle", 16'h0000, 16'(channel_irq[0]));
         toggle_req <= 2'h1;
         @(posedge sys_clk);
         toggle_req <= 2'h0;
         wait_hi(1, k);
      end
      // output compare on channel 1: flag once per modulo period
      wr(ch_a(1, tmr_pkg::CH_OFS_SC), 8'h54);
      wr16(ch_a(1, tmr_pkg::CH_OFS_VHI), 16'h0005);
      rd16(ch_a(1, tmr_pkg::CH_OFS_VHI), v0);
      chk("oc_value", 16'h0005, v0);
      period(2, ch_a(1, tmr_pkg::CH_OFS_SC), 8'h54, k);
      chk("oc_period", 16'h000a, 16'(k));
      // edge pwm: high for value steps of every 10-step period
      wr(ch_a(1, tmr_pkg::CH_OFS_SC), 8'h28);
      wr16(ch_a(1, tmr_pkg::CH_OFS_VHI), 16'h0003);
      repeat (25) @(posedge sys_clk);
      count_hi(1, 10, k);
      chk("epwm_high", 16'h0003, 16'(k));
      chk("epwm_oe", 16'h0001, 16'(pin_oe[1]));
      // center pwm: 18-step period, active for twice the value
      wr(tmr_pkg::ADDR_MAIN_SC, 8'h28);
      repeat (40) @(posedge sys_clk);
      count_hi(1, 18, k);
      chk("center_aligned_pwm_high", 16'h0006, 16'(k));
      for (int i = 0; i < 6; i++) begin
         rd16(tmr_pkg::ADDR_CNT_HI, v0);
         chk("cnt_range", 16'h0001, 16'(v0 <= 16'h0009));
      end
      // center mode without clock loads on the second byte; a control write drops pending bytes
      wr(tmr_pkg::ADDR_MAIN_SC, 8'h20);
      wr16(ch_a(1, tmr_pkg::CH_OFS_VHI), 16'h0007);
      rd16(ch_a(1, tmr_pkg::CH_OFS_VHI), v0);
      chk("center_aligned_pwm_load", 16'h0007, v0);
      wr(ch_a(1, tmr_pkg::CH_OFS_VHI), 8'h01);
      wr(ch_a(1, tmr_pkg::CH_OFS_SC), 8'h28);
      wr(ch_a(1, tmr_pkg::CH_OFS_VLO), 8'h02);
      rd16(ch_a(1, tmr_pkg::CH_OFS_VHI), v0);
      chk("val_discard", 16'h0007, v0);
      background_debug_mode <= 1'b1;
      rd16(ch_a(1, tmr_pkg::CH_OFS_VHI), v0);
      chk("dbg_value", 16'h0007, v0);
      finish_test();
   end
endmodule : testbench
